// File: logic/flash_guard_pkg.sv
// Constants, types and command codes for the flash sector-guard host controller
package flash_guard_pkg;

	// ----------------------------------------
	// Bus widths
	// ----------------------------------------
	localparam int ADDR_W = 21;
	localparam int DATA_W = 16;

	// ----------------------------------------
	// Timing (ns, poll limit in us) and derived clock counts
	// ----------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int T_STROBE_WR_NS = 35;
	localparam int T_ACCESS_RD_NS = 70;
	localparam int T_HOLD_NS = 20;
	localparam int T_RST_PULSE_NS = 500;
	localparam int T_RST_RECOVER_NS = 20000;
	localparam int T_POLL_MAX_US = 500000;
	// Least times round up
	localparam int CYC_STROBE_WR = (T_STROBE_WR_NS * CLK_MHZ + 999) / 1000;
	localparam int CYC_ACCESS_RD = (T_ACCESS_RD_NS * CLK_MHZ + 999) / 1000;
	localparam int CYC_HOLD = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int CYC_RST_PULSE = (T_RST_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int CYC_RST_RECOVER = (T_RST_RECOVER_NS * CLK_MHZ + 999) / 1000;
	localparam int CYC_POLL_MAX = T_POLL_MAX_US * CLK_MHZ;

	// ----------------------------------------
	// Flash bus addresses and data codes
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] A_UNLOCK1 = 21'h000555;
	localparam logic [ADDR_W-1:0] A_UNLOCK2 = 21'h0002AA;
	localparam logic [ADDR_W-1:0] A_ZERO = 21'h000000;
	localparam logic [7:0] A_SEC_IND = 8'h03;
	localparam logic [7:0] A_PROT_VERIFY = 8'h02;
	localparam logic [15:0] D_UNLOCK1 = 16'h00AA;
	localparam logic [15:0] D_UNLOCK2 = 16'h0055;
	localparam logic [15:0] D_AUTOSELECT = 16'h0090;
	localparam logic [15:0] D_SSR_ENTRY = 16'h0088;
	localparam logic [15:0] D_SET_EXIT2 = 16'h0000;
	localparam logic [15:0] D_RESET = 16'h00F0;
	localparam logic [15:0] D_PROGRAM = 16'h00A0;
	localparam logic [15:0] D_ERASE_SETUP = 16'h0080;
	localparam logic [15:0] D_ERASE_GO = 16'h0030;
	localparam logic [15:0] D_GUARD_SET = 16'h0000;
	localparam logic [15:0] D_GUARD_CLEAR = 16'h0001;
	localparam logic [15:0] D_LOCKREG_ENTRY = 16'h0040;
	localparam logic [15:0] D_PGB_ENTRY = 16'h00C0;
	localparam logic [15:0] D_GLOCK_ENTRY = 16'h0050;
	localparam logic [15:0] D_VGB_ENTRY = 16'h00E0;
	localparam logic [7:0] ST_PGM_OK = 8'h00;
	localparam logic [7:0] ST_ERS_OK = 8'h01;
	localparam int TOGGLE_BIT = 6;

	// ----------------------------------------
	// User operation codes
	// ----------------------------------------
	localparam logic [3:0] OP_SEC_IND = 4'h0;
	localparam logic [3:0] OP_PROT_VERIFY = 4'h1;
	localparam logic [3:0] OP_SSR_ENTER = 4'h2;
	localparam logic [3:0] OP_SSR_EXIT = 4'h3;
	localparam logic [3:0] OP_SSR_PROGRAM = 4'h4;
	localparam logic [3:0] OP_LOCKREG_PROG = 4'h5;
	localparam logic [3:0] OP_PGB_PROG = 4'h6;
	localparam logic [3:0] OP_PGB_ERASE_ALL = 4'h7;
	localparam logic [3:0] OP_PGB_READ = 4'h8;
	localparam logic [3:0] OP_GLOCK_SET = 4'h9;
	localparam logic [3:0] OP_VGB_SET = 4'hA;
	localparam logic [3:0] OP_VGB_CLEAR = 4'hB;
	localparam logic [3:0] OP_HW_RESET = 4'hC;

	typedef enum logic [2:0] {SK_WR, SK_RD, SK_POLL_PGM, SK_POLL_ERS, SK_END, SK_RST} step_kind_e;

	typedef struct packed {
		step_kind_e kind;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} step_s;

endpackage : flash_guard_pkg

// File: logic/flash_bus_cycle.sv
// One asynchronous write or read cycle on the flash pins
`timescale 1ns/1ps
module flash_bus_cycle (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	input wire logic write_i,
	input wire logic [flash_guard_pkg::ADDR_W-1:0] addr_i,
	input wire logic [flash_guard_pkg::DATA_W-1:0] wdata_i,
	output logic done_o,
	output logic [flash_guard_pkg::DATA_W-1:0] rdata_o,
	output logic [flash_guard_pkg::ADDR_W-1:0] flash_addr_o,
	output logic [flash_guard_pkg::DATA_W-1:0] flash_dq_o,
	output logic flash_dq_oe_o,
	input wire logic [flash_guard_pkg::DATA_W-1:0] flash_dq_i,
	output logic flash_ce_n_o,
	output logic flash_oe_n_o,
	output logic flash_we_n_o
);

	typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_STROBE, BC_HOLD} bc_state_e;

	bc_state_e state_r;
	logic write_r;
	logic [7:0] cnt_r;

	// ----------------------------------------
	// Cycle sequencing
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= BC_IDLE;
			write_r <= 1'b0;
			cnt_r <= 8'h00;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			case (state_r)
				BC_IDLE: begin
					if (start_i) begin
						write_r <= write_i;
						state_r <= BC_SETUP;
					end
				end
				BC_SETUP: begin
					cnt_r <= write_r ? 8'(flash_guard_pkg::CYC_STROBE_WR - 1) : 8'(flash_guard_pkg::CYC_ACCESS_RD - 1);
					state_r <= BC_STROBE;
				end
				BC_STROBE: begin
					if (cnt_r == 8'h00) begin
						cnt_r <= 8'(flash_guard_pkg::CYC_HOLD - 1);
						state_r <= BC_HOLD;
					end else begin
						cnt_r <= cnt_r - 8'h01;
					end
				end
				default: begin
					if (cnt_r == 8'h00) begin
						done_o <= 1'b1;
						state_r <= BC_IDLE;
					end else begin
						cnt_r <= cnt_r - 8'h01;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Pin drivers, all from flops
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flash_addr_o <= '0;
			flash_dq_o <= '0;
			flash_dq_oe_o <= 1'b0;
			flash_ce_n_o <= 1'b1;
			flash_oe_n_o <= 1'b1;
			flash_we_n_o <= 1'b1;
			rdata_o <= '0;
		end else begin
			if (state_r == BC_IDLE && start_i) begin
				flash_addr_o <= addr_i;
				flash_dq_o <= wdata_i;
				flash_dq_oe_o <= write_i;
				flash_ce_n_o <= 1'b0;
			end else if (state_r == BC_SETUP) begin
				flash_we_n_o <= ~write_r;
				flash_oe_n_o <= write_r;
			end else if (state_r == BC_STROBE && cnt_r == 8'h00) begin
				// Release strobe first; data stays driven through hold
				flash_we_n_o <= 1'b1;
				flash_oe_n_o <= 1'b1;
				flash_ce_n_o <= 1'b1;
				if (!write_r) begin
					rdata_o <= flash_dq_i;
				end
			end else if (state_r == BC_HOLD && cnt_r == 8'h00) begin
				flash_dq_oe_o <= 1'b0;
			end
		end
	end

endmodule : flash_bus_cycle

// File: logic/flash_guard_host.sv
// Host controller that drives sector-guard, lock and security-region sequences
`timescale 1ns/1ps
// Operation
// - Volatile guard change: entry, set/clear, exit
// - Poll toggle bit; then 00h program, 01h erase
// - Unprotect: reset, erase all, reprogram, relock
// - Boot sets global lock early, holds write-protect low
module flash_guard_host #(
	parameter int unsigned POLL_LIMIT = flash_guard_pkg::CYC_POLL_MAX
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic boot_lock_en_i,
	input wire logic wp_hold_i,
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire logic [3:0] cmd_op_i,
	input wire logic [flash_guard_pkg::ADDR_W-1:0] cmd_addr_i,
	input wire logic [flash_guard_pkg::DATA_W-1:0] cmd_data_i,
	output logic done_o,
	output logic fail_o,
	output logic [flash_guard_pkg::DATA_W-1:0] rdata_o,
	output logic [flash_guard_pkg::ADDR_W-1:0] flash_addr_o,
	output logic [flash_guard_pkg::DATA_W-1:0] flash_dq_o,
	output logic flash_dq_oe_o,
	input wire logic [flash_guard_pkg::DATA_W-1:0] flash_dq_i,
	output logic flash_ce_n_o,
	output logic flash_oe_n_o,
	output logic flash_we_n_o,
	output logic flash_reset_n_o,
	output logic write_protect_accel_pin_n_o
);

	typedef enum logic [2:0] {M_IDLE, M_ISSUE, M_WAIT, M_RST, M_DONE} main_state_e;

	main_state_e state_r;
	logic [3:0] op_r;
	logic [3:0] idx_r;
	logic [flash_guard_pkg::ADDR_W-1:0] addr_r;
	logic [flash_guard_pkg::DATA_W-1:0] data_r;
	logic boot_pend_r;
	logic poll_have_r;
	logic poll_prev_r;
	logic [31:0] poll_cnt_r;
	logic rst_phase_r;
	logic [15:0] rst_cnt_r;
	logic bc_start;
	logic bc_done;
	logic [flash_guard_pkg::DATA_W-1:0] bc_rdata;
	flash_guard_pkg::step_s step;
	logic poll_kind;
	logic [7:0] poll_expect;

	// ----------------------------------------
	// Step table: one step per index; a poll step repeats its read until it settles or reaches POLL_LIMIT
	// ----------------------------------------
	function automatic flash_guard_pkg::step_s step_of(input logic [3:0] op, input logic [3:0] idx,
		input logic [flash_guard_pkg::ADDR_W-1:0] sa, input logic [flash_guard_pkg::DATA_W-1:0] wd);
		flash_guard_pkg::step_s s;
		logic [flash_guard_pkg::DATA_W-1:0] entry;
		logic [3:0] k;
		s.kind = flash_guard_pkg::SK_END;
		s.addr = flash_guard_pkg::A_ZERO;
		s.data = '0;
		entry = flash_guard_pkg::D_AUTOSELECT;
		k = idx - 4'h3;
		case (op)
			flash_guard_pkg::OP_SSR_ENTER: entry = flash_guard_pkg::D_SSR_ENTRY;
			flash_guard_pkg::OP_SSR_PROGRAM: entry = flash_guard_pkg::D_PROGRAM;
			flash_guard_pkg::OP_LOCKREG_PROG: entry = flash_guard_pkg::D_LOCKREG_ENTRY;
			flash_guard_pkg::OP_GLOCK_SET: entry = flash_guard_pkg::D_GLOCK_ENTRY;
			flash_guard_pkg::OP_VGB_SET, flash_guard_pkg::OP_VGB_CLEAR: entry = flash_guard_pkg::D_VGB_ENTRY;
			flash_guard_pkg::OP_PGB_PROG, flash_guard_pkg::OP_PGB_ERASE_ALL,
				flash_guard_pkg::OP_PGB_READ: entry = flash_guard_pkg::D_PGB_ENTRY;
			default: entry = flash_guard_pkg::D_AUTOSELECT;
		endcase
		if (op == flash_guard_pkg::OP_HW_RESET) begin
			if (idx == 4'h0) begin
				s.kind = flash_guard_pkg::SK_RST;
			end
		end else if (idx == 4'h0) begin
			s = '{flash_guard_pkg::SK_WR, flash_guard_pkg::A_UNLOCK1, flash_guard_pkg::D_UNLOCK1};
		end else if (idx == 4'h1) begin
			s = '{flash_guard_pkg::SK_WR, flash_guard_pkg::A_UNLOCK2, flash_guard_pkg::D_UNLOCK2};
		end else if (idx == 4'h2) begin
			s = '{flash_guard_pkg::SK_WR, flash_guard_pkg::A_UNLOCK1, entry};
		end else begin
			case (op)
				flash_guard_pkg::OP_SEC_IND, flash_guard_pkg::OP_PROT_VERIFY: begin
					// indicator at 03h; autoselect left with reset command
					if (k == 4'h0) begin
						s.kind = flash_guard_pkg::SK_RD;
						s.addr = (op == flash_guard_pkg::OP_SEC_IND) ? {13'h0000, flash_guard_pkg::A_SEC_IND}
							: {sa[flash_guard_pkg::ADDR_W-1:8], flash_guard_pkg::A_PROT_VERIFY};
					end else if (k == 4'h1) begin
						s = '{flash_guard_pkg::SK_WR, flash_guard_pkg::A_ZERO, flash_guard_pkg::D_RESET};
					end
				end
				flash_guard_pkg::OP_SSR_PROGRAM: begin
					if (k == 4'h0) begin
						s = '{flash_guard_pkg::SK_WR, sa, wd};
					end else if (k == 4'h1) begin
						s.kind = flash_guard_pkg::SK_POLL_PGM;
						s.addr = sa;
					end
				end
				flash_guard_pkg::OP_SSR_EXIT: begin
					if (k == 4'h0) begin
						s = '{flash_guard_pkg::SK_WR, flash_guard_pkg::A_ZERO, flash_guard_pkg::D_SET_EXIT2};
					end
				end
				flash_guard_pkg::OP_SSR_ENTER: s.kind = flash_guard_pkg::SK_END;
				default: begin
					// command-set body, then the set-exit pair
					case (k)
						4'h0: begin
							s.kind = flash_guard_pkg::SK_WR;
							s.addr = sa;
							s.data = (op == flash_guard_pkg::OP_PGB_ERASE_ALL) ? flash_guard_pkg::D_ERASE_SETUP
								: flash_guard_pkg::D_PROGRAM;
							if (op == flash_guard_pkg::OP_PGB_READ) begin
								s.kind = flash_guard_pkg::SK_RD;
							end
						end
						4'h1: begin
							s.kind = flash_guard_pkg::SK_WR;
							s.addr = sa;
							case (op)
								flash_guard_pkg::OP_LOCKREG_PROG: s.data = wd;
								flash_guard_pkg::OP_PGB_ERASE_ALL: s.data = flash_guard_pkg::D_ERASE_GO;
								flash_guard_pkg::OP_VGB_CLEAR: s.data = flash_guard_pkg::D_GUARD_CLEAR;
								default: s.data = flash_guard_pkg::D_GUARD_SET;
							endcase
							if (op == flash_guard_pkg::OP_PGB_READ) begin
								s = '{flash_guard_pkg::SK_WR, flash_guard_pkg::A_ZERO, flash_guard_pkg::D_AUTOSELECT};
							end
						end
						4'h2: begin
							s.addr = sa;
							s.kind = (op == flash_guard_pkg::OP_PGB_ERASE_ALL) ? flash_guard_pkg::SK_POLL_ERS
								: flash_guard_pkg::SK_POLL_PGM;
							if (op == flash_guard_pkg::OP_PGB_READ) begin
								s = '{flash_guard_pkg::SK_WR, flash_guard_pkg::A_ZERO, flash_guard_pkg::D_SET_EXIT2};
							end else if (op == flash_guard_pkg::OP_VGB_SET || op == flash_guard_pkg::OP_VGB_CLEAR) begin
								s = '{flash_guard_pkg::SK_WR, flash_guard_pkg::A_ZERO, flash_guard_pkg::D_AUTOSELECT};
							end
						end
						4'h3: begin
							if (op == flash_guard_pkg::OP_VGB_SET || op == flash_guard_pkg::OP_VGB_CLEAR) begin
								s = '{flash_guard_pkg::SK_WR, flash_guard_pkg::A_ZERO, flash_guard_pkg::D_SET_EXIT2};
							end else if (op != flash_guard_pkg::OP_PGB_READ) begin
								s = '{flash_guard_pkg::SK_WR, flash_guard_pkg::A_ZERO, flash_guard_pkg::D_AUTOSELECT};
							end
						end
						4'h4: begin
							if (op != flash_guard_pkg::OP_PGB_READ && op != flash_guard_pkg::OP_VGB_SET
								&& op != flash_guard_pkg::OP_VGB_CLEAR) begin
								s = '{flash_guard_pkg::SK_WR, flash_guard_pkg::A_ZERO, flash_guard_pkg::D_SET_EXIT2};
							end
						end
						default: s.kind = flash_guard_pkg::SK_END;
					endcase
				end
			endcase
		end
		return s;
	endfunction : step_of

	// ----------------------------------------
	// Step decode
	// ----------------------------------------
	always_comb begin
		step = step_of(op_r, idx_r, addr_r, data_r);
		poll_kind = (step.kind == flash_guard_pkg::SK_POLL_PGM) || (step.kind == flash_guard_pkg::SK_POLL_ERS);
		poll_expect = (step.kind == flash_guard_pkg::SK_POLL_ERS) ? flash_guard_pkg::ST_ERS_OK
			: flash_guard_pkg::ST_PGM_OK;
	end

	assign bc_start = (state_r == M_ISSUE) && (step.kind != flash_guard_pkg::SK_END)
		&& (step.kind != flash_guard_pkg::SK_RST);
	assign cmd_ready_o = (state_r == M_IDLE) && !boot_pend_r;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= M_IDLE;
			op_r <= 4'h0;
			idx_r <= 4'h0;
			addr_r <= '0;
			data_r <= '0;
			boot_pend_r <= 1'b1;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			case (state_r)
				M_IDLE: begin
					idx_r <= 4'h0;
					if (boot_pend_r) begin
						boot_pend_r <= 1'b0;
						if (boot_lock_en_i) begin
							op_r <= flash_guard_pkg::OP_GLOCK_SET;
							addr_r <= flash_guard_pkg::A_ZERO;
							state_r <= M_ISSUE;
						end
					end else if (cmd_valid_i) begin
						op_r <= cmd_op_i;
						addr_r <= cmd_addr_i;
						data_r <= cmd_data_i;
						state_r <= M_ISSUE;
					end
				end
				M_ISSUE: begin
					if (step.kind == flash_guard_pkg::SK_END) begin
						state_r <= M_DONE;
					end else if (step.kind == flash_guard_pkg::SK_RST) begin
						state_r <= M_RST;
					end else begin
						state_r <= M_WAIT;
					end
				end
				M_WAIT: begin
					if (bc_done) begin
						state_r <= M_ISSUE;
						// non-poll steps advance at once; poll steps advance only once toggling stops or times out
						if (!poll_kind || (poll_have_r && (bc_rdata[flash_guard_pkg::TOGGLE_BIT] == poll_prev_r
							|| poll_cnt_r >= POLL_LIMIT))) begin
							idx_r <= idx_r + 4'h1;
						end
					end
				end
				M_RST: begin
					if (rst_phase_r && rst_cnt_r == 16'h0000) begin
						state_r <= M_DONE;
					end
				end
				default: begin
					done_o <= 1'b1;
					state_r <= M_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Toggle polling and result
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			poll_have_r <= 1'b0;
			poll_prev_r <= 1'b0;
			poll_cnt_r <= 32'h0000_0000;
			fail_o <= 1'b0;
			rdata_o <= '0;
		end else if (state_r == M_IDLE) begin
			poll_have_r <= 1'b0;
			poll_cnt_r <= 32'h0000_0000;
			if (cmd_valid_i || boot_pend_r) begin
				fail_o <= 1'b0;
			end
		end else if (state_r == M_WAIT && bc_done) begin
			if (step.kind == flash_guard_pkg::SK_RD) begin
				// guard status or indicator comes back here
				rdata_o <= bc_rdata;
			end else if (poll_kind) begin
				poll_prev_r <= bc_rdata[flash_guard_pkg::TOGGLE_BIT];
				poll_cnt_r <= poll_cnt_r + 32'h0000_0001;
				if (!poll_have_r) begin
					poll_have_r <= 1'b1;
				end else if (bc_rdata[flash_guard_pkg::TOGGLE_BIT] == poll_prev_r) begin
					// settled status must match 00h or 01h
					rdata_o <= bc_rdata;
					fail_o <= (bc_rdata[7:0] != poll_expect);
					poll_have_r <= 1'b0;
					poll_cnt_r <= 32'h0000_0000;
				end else if (poll_cnt_r >= POLL_LIMIT) begin
					// locked guard bits never finish: time out
					fail_o <= 1'b1;
					poll_have_r <= 1'b0;
					poll_cnt_r <= 32'h0000_0000;
				end
			end
		end
	end

	// ----------------------------------------
	// Hardware reset pulse and write protect
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_phase_r <= 1'b0;
			rst_cnt_r <= 16'h0000;
			flash_reset_n_o <= 1'b1;
			write_protect_accel_pin_n_o <= 1'b1;
		end else begin
			// boot sector guarded by holding the pin low
			write_protect_accel_pin_n_o <= ~wp_hold_i;
			if (state_r == M_ISSUE && step.kind == flash_guard_pkg::SK_RST) begin
				// only a hardware reset frees the global lock
				flash_reset_n_o <= 1'b0;
				rst_phase_r <= 1'b0;
				rst_cnt_r <= 16'(flash_guard_pkg::CYC_RST_PULSE - 1);
			end else if (state_r == M_RST) begin
				if (rst_cnt_r != 16'h0000) begin
					rst_cnt_r <= rst_cnt_r - 16'h0001;
				end else if (!rst_phase_r) begin
					flash_reset_n_o <= 1'b1;
					rst_phase_r <= 1'b1;
					rst_cnt_r <= 16'(flash_guard_pkg::CYC_RST_RECOVER - 1);
				end
			end
		end
	end

	// ----------------------------------------
	// Bus cycle engine
	// ----------------------------------------
	flash_bus_cycle u_bus (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.start_i(bc_start),
		.write_i(step.kind == flash_guard_pkg::SK_WR),
		.addr_i(step.addr),
		.wdata_i(step.data),
		.done_o(bc_done),
		.rdata_o(bc_rdata),
		.flash_addr_o(flash_addr_o),
		.flash_dq_o(flash_dq_o),
		.flash_dq_oe_o(flash_dq_oe_o),
		.flash_dq_i(flash_dq_i),
		.flash_ce_n_o(flash_ce_n_o),
		.flash_oe_n_o(flash_oe_n_o),
		.flash_we_n_o(flash_we_n_o)
	);

endmodule : flash_guard_host

// File: dv/flash_guard_host_props.sv
// Pin-level and handshake assertions for the sector-guard host controller
`timescale 1ns/1ps
module flash_guard_host_props #(
	parameter int unsigned POLL_LIMIT = 20
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic wp_hold_i,
	input wire logic cmd_valid_i,
	input wire logic cmd_ready_o,
	input wire logic done_o,
	input wire logic [flash_guard_pkg::DATA_W-1:0] flash_dq_o,
	input wire logic flash_dq_oe_o,
	input wire logic flash_ce_n_o,
	input wire logic flash_oe_n_o,
	input wire logic flash_we_n_o,
	input wire logic flash_reset_n_o,
	input wire logic write_protect_accel_pin_n_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_wr_low; !flash_we_n_o [*4] ##1 flash_we_n_o; endsequence
	sequence s_rd_low; !flash_oe_n_o [*7] ##1 flash_oe_n_o; endsequence
	sequence s_wr_hold; (flash_dq_oe_o && $stable(flash_dq_o)) [*2]; endsequence
	property p_excl; !(!flash_we_n_o && !flash_oe_n_o); endproperty
	property p_we_ce; !flash_we_n_o |-> !flash_ce_n_o; endproperty
	property p_we_drive; !flash_we_n_o |-> flash_dq_oe_o; endproperty
	property p_rd_float; !flash_oe_n_o |-> !flash_dq_oe_o; endproperty
	property p_we_width; $fell(flash_we_n_o) |-> s_wr_low; endproperty
	property p_oe_width; $fell(flash_oe_n_o) |-> s_rd_low; endproperty
	property p_wr_hold; $rose(flash_we_n_o) |-> s_wr_hold; endproperty
	property p_done; done_o |=> !done_o; endproperty
	property p_accept; cmd_valid_i && cmd_ready_o |=> !cmd_ready_o && !done_o; endproperty
	property p_wp; 1'b1 |=> write_protect_accel_pin_n_o == !$past(wp_hold_i); endproperty
	property p_rst; $fell(flash_reset_n_o) |-> !flash_reset_n_o [*8]; endproperty
	a_excl: assert property (p_excl) else $error("both strobes low");
	a_we_ce: assert property (p_we_ce) else $error("write strobe without select");
	a_we_drive: assert property (p_we_drive) else $error("write strobe without data");
	a_rd_float: assert property (p_rd_float) else $error("data driven during read");
	a_we_width: assert property (p_we_width) else $error("write strobe width");
	a_oe_width: assert property (p_oe_width) else $error("read strobe width");
	a_wr_hold: assert property (p_wr_hold) else $error("write data hold");
	a_done: assert property (p_done) else $error("done longer than a cycle");
	a_accept: assert property (p_accept) else $error("ready after accept");
	a_wp: assert property (p_wp) else $error("write protect pin");
	a_rst: assert property (p_rst) else $error("reset pulse short");
endmodule : flash_guard_host_props
bind flash_guard_host flash_guard_host_props #(.POLL_LIMIT(POLL_LIMIT)) u_props (.clk_sys_i, .rst_n_i,
	.wp_hold_i, .cmd_valid_i, .cmd_ready_o, .done_o, .flash_dq_o, .flash_dq_oe_o, .flash_ce_n_o,
	.flash_oe_n_o, .flash_we_n_o, .flash_reset_n_o, .write_protect_accel_pin_n_o);

// File: dv/flash_guard_device_model.sv
// Behavioural flash device: guard bits, global lock, status polling
`timescale 1ns/1ps
module flash_guard_device_model #(
	parameter logic FACTORY_LOCKED = 1'b0
) (
	input wire logic [flash_guard_pkg::ADDR_W-1:0] flash_addr_i,
	input wire logic [flash_guard_pkg::DATA_W-1:0] flash_dq_i,
	input wire logic flash_we_n_i,
	input wire logic flash_oe_n_i,
	input wire logic flash_reset_n_i,
	output logic [flash_guard_pkg::DATA_W-1:0] dq_o
);
	logic [15:0] pgb_r = 16'hFFFF;
	logic [15:0] vgb_r = 16'hFFFF;
	logic glock_r = 1'b1;
	logic hang_r = 1'b0;
	logic st_v_r = 1'b0;
	logic tog_r = 1'b1;
	logic [7:0] mode_r = 8'h00;
	logic [7:0] pend_r = 8'h00;
	logic [7:0] stat_r = 8'h00;
	logic [1:0] stage_r = 2'd0;
	logic [1:0] busy_r = 2'd0;
	logic [15:0] rv_r = 16'h0000;
	logic [3:0] s;
	logic [15:0] d;
	assign s = flash_addr_i[11:8];
	assign d = flash_dq_i;
	// Released bus never shows the last word
	assign dq_o = flash_oe_n_i ? ~rv_r : rv_r;
	always @(posedge flash_we_n_i or negedge flash_oe_n_i or negedge flash_reset_n_i) begin
		if (!flash_reset_n_i) begin
			glock_r = 1'b1;
			vgb_r = 16'hFFFF;
			mode_r = 8'h00;
			hang_r = 1'b0;
			busy_r = 2'd0;
			st_v_r = 1'b0;
			stage_r = 2'd0;
		end else if (!flash_oe_n_i) begin
			if (hang_r || busy_r != 2'd0) begin
				rv_r = {9'h000, tog_r, 6'h00};
				tog_r = ~tog_r;
				if (busy_r != 2'd0) busy_r = busy_r - 2'd1;
			end else if (st_v_r) rv_r = {8'h00, stat_r};
			else if (mode_r == 8'h90) rv_r = (flash_addr_i[7:0] == 8'h03) ? {8'h00, FACTORY_LOCKED, 7'h00}
				: {15'h0000, ~(pgb_r[s] & vgb_r[s])};
			else if (mode_r == 8'hC0) rv_r = {15'h0000, pgb_r[s]};
			else rv_r = 16'h0000;
		end else if (stage_r == 2'd2 && flash_addr_i == 21'h000555) begin
			mode_r = d[7:0];
			stage_r = 2'd0;
		end else if (d == 16'h00AA && flash_addr_i == 21'h000555) stage_r = 2'd1;
		else if (stage_r == 2'd1 && d == 16'h0055) stage_r = 2'd2;
		else if (d == 16'h00F0) mode_r = 8'h00;
		else if ((pend_r == 8'h90 || mode_r == 8'h90) && d == 16'h0000) begin
			mode_r = 8'h00;
			pend_r = 8'h00;
			hang_r = 1'b0;
			st_v_r = 1'b0;
		end else if (pend_r == 8'hA0 || (pend_r == 8'h80 && d == 16'h0030)) begin
			tog_r = 1'b1;
			pend_r = 8'h00;
			if (mode_r == 8'hE0) vgb_r[s] = d[0];
			else if (mode_r == 8'hC0 && !glock_r) hang_r = 1'b1;
			else begin
				if (mode_r == 8'h50) glock_r = 1'b0;
				else if (mode_r == 8'hC0 && d == 16'h0030) pgb_r = 16'hFFFF;
				else if (mode_r == 8'hC0) pgb_r[s] = 1'b0;
				busy_r = 2'd3;
				st_v_r = 1'b1;
				stat_r = {7'h00, d == 16'h0030};
			end
		end else pend_r = d[7:0];
	end
endmodule : flash_guard_device_model

// File: dv/flash_guard_host_test.sv
// Self-checking bench for the sector-guard host controller
`timescale 1ns/1ps
module flash_guard_host_test;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic wp_hold_i = 1'b0;
	logic cmd_valid_i = 1'b0;
	logic boot_lock_en_i = 1'b0;
	logic [3:0] cmd_op_i = 4'h0;
	logic [20:0] cmd_addr_i = 21'h000000;
	logic [15:0] cmd_data_i = 16'h0000;
	logic cmd_ready_o, done_o, fail_o, flash_dq_oe_o, flash_ce_n_o, flash_oe_n_o, flash_we_n_o;
	logic flash_reset_n_o, wp_pin_n;
	logic [15:0] rdata_o, flash_dq_o, dev_dq, dq_wire;
	logic [20:0] flash_addr_o;
	int num_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	assign dq_wire = flash_dq_oe_o ? flash_dq_o : dev_dq;
	always #5 clk_sys_i = ~clk_sys_i;
	flash_guard_host #(.POLL_LIMIT(20)) dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .boot_lock_en_i(boot_lock_en_i),
		.wp_hold_i(wp_hold_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_op_i(cmd_op_i),
		.cmd_addr_i(cmd_addr_i), .cmd_data_i(cmd_data_i), .done_o(done_o), .fail_o(fail_o), .rdata_o(rdata_o),
		.flash_addr_o(flash_addr_o), .flash_dq_o(flash_dq_o), .flash_dq_oe_o(flash_dq_oe_o), .flash_dq_i(dq_wire),
		.flash_ce_n_o(flash_ce_n_o), .flash_oe_n_o(flash_oe_n_o), .flash_we_n_o(flash_we_n_o),
		.flash_reset_n_o(flash_reset_n_o), .write_protect_accel_pin_n_o(wp_pin_n));
	flash_guard_device_model dev (.flash_addr_i(flash_addr_o), .flash_dq_i(dq_wire), .flash_we_n_i(flash_we_n_o),
		.flash_oe_n_i(flash_oe_n_o), .flash_reset_n_i(flash_reset_n_o), .dq_o(dev_dq));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
			num_errors++;
		end
	endtask : check
	task automatic run_op(input logic [3:0] op, input logic [3:0] sec);
		int n;
		n = 0;
		@(posedge clk_sys_i) #1;
		cmd_op_i = op;
		cmd_addr_i = {9'h000, sec, 8'h00};
		cmd_valid_i = 1'b1;
		while (cmd_ready_o !== 1'b1) @(posedge clk_sys_i) #1;
		@(posedge clk_sys_i) #1;
		cmd_valid_i = 1'b0;
		while (done_o !== 1'b1 && n < 4000) begin
			@(posedge clk_sys_i) #1;
			n++;
		end
		if (n == 4000) begin
			num_errors++;
			summarize();
		end
	endtask : run_op
	task automatic t_delivered();
		run_op(flash_guard_pkg::OP_SEC_IND, 4'h0);
		check(rdata_o & 16'h0080, 16'h0000);
		run_op(flash_guard_pkg::OP_PROT_VERIFY, 4'h1);
		check(rdata_o, 16'h0000);
	endtask : t_delivered
	task automatic t_persistent();
		run_op(flash_guard_pkg::OP_PGB_PROG, 4'h1);
		check({15'h0000, fail_o}, 16'h0000);
		check(rdata_o, 16'h0000);
		run_op(flash_guard_pkg::OP_PGB_READ, 4'h1);
		check(rdata_o, 16'h0000);
		run_op(flash_guard_pkg::OP_PROT_VERIFY, 4'h1);
		check(rdata_o, 16'h0001);
		run_op(flash_guard_pkg::OP_PROT_VERIFY, 4'h2);
		check(rdata_o, 16'h0000);
	endtask : t_persistent
	task automatic t_volatile();
		run_op(flash_guard_pkg::OP_VGB_SET, 4'h2);
		run_op(flash_guard_pkg::OP_PROT_VERIFY, 4'h2);
		check(rdata_o, 16'h0001);
		run_op(flash_guard_pkg::OP_VGB_CLEAR, 4'h2);
		run_op(flash_guard_pkg::OP_PROT_VERIFY, 4'h2);
		check(rdata_o, 16'h0000);
	endtask : t_volatile
	task automatic t_global_lock();
		run_op(flash_guard_pkg::OP_GLOCK_SET, 4'h0);
		check({15'h0000, fail_o}, 16'h0000);
		run_op(flash_guard_pkg::OP_PGB_ERASE_ALL, 4'h1);
		check({15'h0000, fail_o}, 16'h0001);
		run_op(flash_guard_pkg::OP_PROT_VERIFY, 4'h1);
		check(rdata_o, 16'h0001);
	endtask : t_global_lock
	task automatic t_unprotect();
		run_op(flash_guard_pkg::OP_HW_RESET, 4'h0);
		run_op(flash_guard_pkg::OP_PGB_ERASE_ALL, 4'h1);
		check({15'h0000, fail_o}, 16'h0000);
		check(rdata_o, 16'h0001);
		run_op(flash_guard_pkg::OP_PROT_VERIFY, 4'h1);
		check(rdata_o, 16'h0000);
	endtask : t_unprotect
	task automatic t_write_protect();
		@(posedge clk_sys_i) #1;
		wp_hold_i = 1'b1;
		repeat (2) @(posedge clk_sys_i);
		#1 check({15'h0000, wp_pin_n}, 16'h0000);
		wp_hold_i = 1'b0;
		repeat (2) @(posedge clk_sys_i);
		#1 check({15'h0000, wp_pin_n}, 16'h0001);
	endtask : t_write_protect
	task automatic t_security();
		cmd_data_i = 16'h1234;
		run_op(flash_guard_pkg::OP_SSR_ENTER, 4'h0);
		run_op(flash_guard_pkg::OP_SSR_PROGRAM, 4'h0);
		check(16'(fail_o), 16'h0000);
		run_op(flash_guard_pkg::OP_SSR_EXIT, 4'h0);
		cmd_data_i = 16'hFFFE;
		run_op(flash_guard_pkg::OP_LOCKREG_PROG, 4'h1);
		check(16'(fail_o), 16'h0000);
	endtask : t_security
	task automatic t_boot();
		boot_lock_en_i = 1'b1;
		rst_n_i = 1'b0;
		@(posedge clk_sys_i) #1 rst_n_i = 1'b1;
		run_op(flash_guard_pkg::OP_PGB_ERASE_ALL, 4'h1);
		check(16'(fail_o), 16'h0001);
	endtask : t_boot
	task automatic summarize();
		if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : summarize
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 30000) begin
			num_errors++;
			summarize();
		end
	end
	initial begin
		repeat (3) @(posedge clk_sys_i);
		#1 rst_n_i = 1'b1;
		t_delivered();
		t_persistent();
		t_volatile();
		t_global_lock();
		t_unprotect();
		t_security();
		t_boot();
		t_write_protect();
		summarize();
	end
endmodule : flash_guard_host_test
